// [rtl/uart_irq_wake_map.svh]
// register map, field positions, reset values and counts of the serial-port
// interrupt and wake-up block; included by the package, the main module and the bench
`ifndef UART_IRQ_WAKE_MAP_SVH
`define UART_IRQ_WAKE_MAP_SVH

// byte addresses on the apb side
`define UIW_ADDR_W 8
`define UIW_OFF_CTRL 8'h00
`define UIW_OFF_FLAGS 8'h04
`define UIW_OFF_ISTAT 8'h08
`define UIW_OFF_ICLR 8'h0C
`define UIW_OFF_IEN 8'h10

// control register fields
`define UIW_CTRL_W 11
`define UIW_CTRL_RST 11'h000
`define UIW_C_PORT_ON 0
`define UIW_C_RECEIVER_ON 1
`define UIW_C_PARITY_ON 2
`define UIW_C_NINE_BIT 3
`define UIW_C_ADDR_DET 4
`define UIW_C_WAKE 5
`define UIW_C_TXE_IE 6
`define UIW_C_TXI_IE 7
`define UIW_C_RX_IE 8
`define UIW_C_PORT_IE 9
`define UIW_C_GLOBAL_IE 10

// event bit positions, shared by status, clear and enable
`define UIW_EV_W 6
`define UIW_EV_RST 6'h00
`define UIW_EV_TXE 0
`define UIW_EV_TXI 1
`define UIW_EV_RXA 2
`define UIW_EV_OVR 3
`define UIW_EV_ADR 4
`define UIW_EV_WAKE 5

// flags register fields
`define UIW_F_TXE 0
`define UIW_F_TXI 1
`define UIW_F_RXA 2
`define UIW_F_OVR 3
`define UIW_F_CLK_ON 4
`define UIW_F_ARMED 5
`define UIW_F_RESTART 6
`define UIW_F_PEND 7

// received word and timing
`define UIW_WORD_W 9
`define UIW_TOP9 8
`define UIW_TOP8 7
`define UIW_RESTART_CYCLES 16
`define UIW_CNT_W 16

`endif

// [rtl/uart_irq_wake_pkg.sv]
// types of the serial-port interrupt and wake-up block
// assumes uart_irq_wake_map.svh sits on the include path
`include "uart_irq_wake_map.svh"

package uart_irq_wake_pkg;

    // wake-up sequencer, one-hot
    typedef enum logic [2:0] {
        WAKE_RUN = 3'b001,
        WAKE_ARMED = 3'b010,
        WAKE_RESTART = 3'b100
    } wake_e;

    // whole state of the main module
    typedef struct packed {
        logic [`UIW_CTRL_W-1:0] ctrl;
        logic [`UIW_EV_W-1:0] istat;
        logic [`UIW_EV_W-1:0] ien;
        logic [`UIW_EV_W-1:0] src_q;
        logic pend;
        wake_e wake;
        logic [`UIW_CNT_W-1:0] cnt;
        logic wake_done;
        logic irq_n;
        logic irq;
        logic wake_req;
        logic rx_ignore;
        logic uart_freeze;
        logic pready;
        logic pslverr;
        logic [31:0] prdata;
    } core_s;

    // whole state of the pin synchroniser
    typedef struct packed {
        logic rx_a;
        logic rx_b;
        logic rx_c;
        logic clk_a;
        logic clk_b;
        logic fall;
    } sync_s;

endpackage

// [rtl/pin_sync_if.sv]
// synchronised pin levels passed from the synchroniser to the main module
// assumes both ends run on pclk
`timescale 1ns/1ns

interface pin_sync_if;
    logic rx_level; // receive pin, resynchronised
    logic rx_fall; // one-cycle pulse on a falling receive edge
    logic clk_on; // serial clock running, resynchronised

    modport src (output rx_level, output rx_fall, output clk_on);
    modport dst (input rx_level, input rx_fall, input clk_on);
endinterface

// [rtl/uart_pin_sync.sv]
// three-flop synchroniser for the receive pin and two-flop synchroniser for the serial-clock status
// assumes the inputs are asynchronous to pclk
`timescale 1ns/1ns

module uart_pin_sync (
    input wire logic pclk, // system clock
    input wire logic presetn, // async reset, low
    input wire logic rx_pin, // receive pin, async
    input wire logic uart_clk_on, // serial clock running, async
    pin_sync_if.src sync // resynchronised levels
);
    uart_irq_wake_pkg::sync_s s; // all state
    uart_irq_wake_pkg::sync_s next_s; // next state

    ////////////////////////////////////////////////////////////////////////
    // first stages feed only the second; the edge looks at stages two/three
    always_comb begin
        next_s = s;
        next_s.rx_a = rx_pin;
        next_s.rx_b = s.rx_a;
        next_s.rx_c = s.rx_b;
        next_s.clk_a = uart_clk_on;
        next_s.clk_b = s.clk_a;
        next_s.fall = s.rx_c & ~s.rx_b;
    end

    // idle line is high, so the receive chain resets high to avoid a false edge
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s <= '{rx_a: 1'b1, rx_b: 1'b1, rx_c: 1'b1, default: 1'b0};
        end else begin
            s <= next_s;
        end
    end

    assign sync.rx_level = s.rx_c;
    assign sync.rx_fall = s.fall;
    assign sync.clk_on = s.clk_b;
endmodule

// [rtl/uart_irq_wake.sv]
// serial-port interrupt combiner, address-detect qualifier and rx wake-up
// assumes datapath flags arrive on pclk; rx pin and clock status are async
//
// Implementation choices: the register addresses and the APB interface to the registers.
`timescale 1ns/1ns
`include "uart_irq_wake_map.svh"

module uart_irq_wake #(
    parameter int RESTART_CYCLES = `UIW_RESTART_CYCLES // clock restart delay
) (
    input wire logic pclk, // system clock, 100 MHz
    input wire logic presetn, // async reset, low
    input wire logic psel, // apb select
    input wire logic penable, // apb access phase
    input wire logic pwrite, // apb write
    input wire logic [`UIW_ADDR_W-1:0] paddr, // apb byte address
    input wire logic [31:0] pwdata, // apb write data
    output logic [31:0] prdata, // apb read data
    output logic pready, // apb ready
    output logic pslverr, // apb error on unmapped address
    input wire logic tx_empty, // transmit register empty flag
    input wire logic tx_idle, // transmitter idle flag
    input wire logic rx_avail_flag, // receive data available flag
    input wire logic rx_overrun, // receive overrun flag
    input wire logic [`UIW_WORD_W-1:0] rx_word, // last received word
    input wire logic stack_full, // core call stack full
    input wire logic rx_pin, // receive pin, async
    input wire logic uart_clk_on, // serial clock running, async
    output logic irq_n, // vector request pulse, low
    output logic irq, // level, enabled sticky status set
    output logic wake_req, // one-cycle wake pulse to the clock control
    output logic rx_ignore, // receiver must drop data now
    output logic uart_freeze // datapath holds its state
);
    uart_irq_wake_pkg::core_s s; // all state
    uart_irq_wake_pkg::core_s next_s; // next state
    pin_sync_if sync (); // resynchronised pins

    logic [`UIW_CNT_W-1:0] restart_last; // final count of the restart wait
    assign restart_last = `UIW_CNT_W'(RESTART_CYCLES - 1);

    ////////////////////////////////////////////////////////////////////////
    // pin synchroniser
    uart_pin_sync u_sync (
        .pclk(pclk),
        .presetn(presetn),
        .rx_pin(rx_pin),
        .uart_clk_on(uart_clk_on),
        .sync(sync)
    );

    ////////////////////////////////////////////////////////////////////////
    // decode helpers

    // true when the address hits a mapped word
    function automatic logic mapped(input logic [`UIW_ADDR_W-1:0] a);
        mapped = (a == `UIW_OFF_CTRL) || (a == `UIW_OFF_FLAGS) ||
            (a == `UIW_OFF_ISTAT) || (a == `UIW_OFF_ICLR) ||
            (a == `UIW_OFF_IEN);
    endfunction

    // one control bit
    function automatic logic cbit(input logic [`UIW_CTRL_W-1:0] c,
            input int idx);
        cbit = c[idx];
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // combinational terms
    logic top_bit; // highest bit of the received word
    logic addr_word; // received word is an address
    logic [`UIW_EV_W-1:0] lvl; // masked source levels
    logic [`UIW_EV_W-1:0] ev; // rising events
    logic vec_en; // global and port enables both set
    logic arm_ok; // wake-up is armed by software
    logic setup; // apb access phase, first cycle
    logic commit; // apb edge where the transfer completes

    always_comb begin
        // 9th bit in nine-bit mode, else the 8th
        top_bit = cbit(s.ctrl, `UIW_C_NINE_BIT) ? rx_word[`UIW_TOP9] :
            rx_word[`UIW_TOP8];
        // address word only counts while address mode is on
        addr_word = cbit(s.ctrl, `UIW_C_ADDR_DET) & top_bit;
        vec_en = cbit(s.ctrl, `UIW_C_GLOBAL_IE) & cbit(s.ctrl, `UIW_C_PORT_IE);
        arm_ok = cbit(s.ctrl, `UIW_C_WAKE) & cbit(s.ctrl, `UIW_C_PORT_ON) &
            cbit(s.ctrl, `UIW_C_RECEIVER_ON) & cbit(s.ctrl, `UIW_C_RX_IE);
        // each transmit source has its own mask
        lvl[`UIW_EV_TXE] = tx_empty & cbit(s.ctrl, `UIW_C_TXE_IE);
        lvl[`UIW_EV_TXI] = tx_idle & cbit(s.ctrl, `UIW_C_TXI_IE);
        // both receive sources share one mask
        lvl[`UIW_EV_OVR] = rx_overrun & cbit(s.ctrl, `UIW_C_RX_IE);
        // address mode drops data words; without it every flag counts
        lvl[`UIW_EV_RXA] = rx_avail_flag & cbit(s.ctrl, `UIW_C_RX_IE) &
            (~cbit(s.ctrl, `UIW_C_ADDR_DET) | top_bit);
        // address detect has no flag of its own, only its enable
        lvl[`UIW_EV_ADR] = rx_avail_flag & addr_word;
        // wake source is the end of the restart wait
        lvl[`UIW_EV_WAKE] = s.wake_done;
        ev = lvl & ~s.src_q;
        setup = psel & penable & ~s.pready;
        commit = psel & penable & s.pready;
    end

    ////////////////////////////////////////////////////////////////////////
    // next state
    always_comb begin
        next_s = s;
        next_s.src_q = lvl;
        next_s.wake_req = 1'b0;
        next_s.wake_done = 1'b0;
        next_s.irq_n = 1'b1;

        // apb: one wait state, then ready for a single cycle
        next_s.pready = setup;
        // error stands only beside its ready pulse, never into idle
        next_s.pslverr = setup & ~mapped(paddr);
        if (setup) begin
            next_s.prdata = 32'h0000_0000;
            if (!pwrite) begin
                case (paddr)
                    `UIW_OFF_CTRL: begin
                        next_s.prdata[`UIW_CTRL_W-1:0] = s.ctrl;
                    end
                    `UIW_OFF_FLAGS: begin
                        // live datapath flags, clock status, wake state and pending vector, read-only here
                        next_s.prdata[`UIW_F_TXE] = tx_empty;
                        next_s.prdata[`UIW_F_TXI] = tx_idle;
                        next_s.prdata[`UIW_F_RXA] = rx_avail_flag;
                        next_s.prdata[`UIW_F_OVR] = rx_overrun;
                        next_s.prdata[`UIW_F_CLK_ON] = sync.clk_on;
                        next_s.prdata[`UIW_F_ARMED] =
                            (s.wake == uart_irq_wake_pkg::WAKE_ARMED);
                        next_s.prdata[`UIW_F_RESTART] =
                            (s.wake == uart_irq_wake_pkg::WAKE_RESTART);
                        next_s.prdata[`UIW_F_PEND] = s.pend;
                    end
                    `UIW_OFF_ISTAT: begin
                        next_s.prdata[`UIW_EV_W-1:0] = s.istat;
                    end
                    `UIW_OFF_IEN: begin
                        next_s.prdata[`UIW_EV_W-1:0] = s.ien;
                    end
                    // clear register reads zero, unmapped reads zero
                    default: begin
                        next_s.prdata = 32'h0000_0000;
                    end
                endcase
            end
        end

        // sticky status: an event in the clearing cycle still sets
        next_s.istat = s.istat | ev;
        if (commit && pwrite) begin
            case (paddr)
                `UIW_OFF_CTRL: begin
                    next_s.ctrl = pwdata[`UIW_CTRL_W-1:0];
                end
                `UIW_OFF_ICLR: begin
                    next_s.istat = (s.istat & ~pwdata[`UIW_EV_W-1:0]) | ev;
                end
                `UIW_OFF_IEN: begin
                    next_s.ien = pwdata[`UIW_EV_W-1:0];
                end
                // flags and status ignore writes
                default: begin
                    next_s.ien = s.ien;
                end
            endcase
        end
        next_s.irq = |(next_s.istat & next_s.ien);

        // wake-up sequencer
        case (s.wake)
            uart_irq_wake_pkg::WAKE_RUN: begin
                // armed only while the serial clock is off
                if (!sync.clk_on && arm_ok) begin
                    next_s.wake = uart_irq_wake_pkg::WAKE_ARMED;
                end
            end
            uart_irq_wake_pkg::WAKE_ARMED: begin
                if (sync.rx_fall) begin
                    next_s.wake = uart_irq_wake_pkg::WAKE_RESTART;
                    next_s.wake_req = 1'b1;
                    next_s.cnt = `UIW_CNT_W'(0);
                end else if (sync.clk_on || !arm_ok) begin
                    next_s.wake = uart_irq_wake_pkg::WAKE_RUN;
                end
            end
            uart_irq_wake_pkg::WAKE_RESTART: begin
                // receiver drops data and vectors wait until the count ends
                if (s.cnt == restart_last) begin
                    next_s.wake = uart_irq_wake_pkg::WAKE_RUN;
                    next_s.wake_done = 1'b1;
                end else begin
                    next_s.cnt = s.cnt + `UIW_CNT_W'(1);
                end
            end
            default: begin
                next_s.wake = uart_irq_wake_pkg::WAKE_RUN;
            end
        endcase
        next_s.rx_ignore =
            (next_s.wake == uart_irq_wake_pkg::WAKE_RESTART);

        // datapath holds its state, registers are untouched by the stop
        next_s.uart_freeze = ~sync.clk_on;

        // vector request: any masked source, but only with both enables;
        // a wake with an enable off restarts the clock and sets status, but sends no vector
        if (s.pend && vec_en && !stack_full &&
                s.wake != uart_irq_wake_pkg::WAKE_RESTART) begin
            next_s.irq_n = 1'b0;
            next_s.pend = 1'b0;
        end
        if ((|ev) && vec_en) begin
            next_s.pend = 1'b1;
        end
        // dropping either enable abandons what was waiting
        if (!vec_en) begin
            next_s.pend = 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // state register; nothing here reacts to halt, so values survive it
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s <= '{
                ctrl: `UIW_CTRL_RST,
                istat: `UIW_EV_RST,
                ien: `UIW_EV_RST,
                src_q: `UIW_EV_RST,
                pend: 1'b0,
                wake: uart_irq_wake_pkg::WAKE_RUN,
                cnt: `UIW_CNT_W'(0),
                wake_done: 1'b0,
                irq_n: 1'b1,
                irq: 1'b0,
                wake_req: 1'b0,
                rx_ignore: 1'b0,
                uart_freeze: 1'b1,
                pready: 1'b0,
                pslverr: 1'b0,
                prdata: 32'h0000_0000
            };
        end else begin
            s <= next_s;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // outputs straight from the state register
    assign prdata = s.prdata;
    assign pready = s.pready;
    assign pslverr = s.pslverr;
    assign irq_n = s.irq_n;
    assign irq = s.irq;
    assign wake_req = s.wake_req;
    assign rx_ignore = s.rx_ignore;
    assign uart_freeze = s.uart_freeze;
endmodule

// [sim/uart_irq_wake_assertions.sv]
// port checks for the serial-port interrupt and wake-up block
// assumes one pclk domain with presetn as its async reset
`timescale 1ns/1ns

module uart_irq_wake_assertions #(
    parameter int RESTART_CYCLES = 16 // restart wait length
) (
    input wire logic pclk, // system clock
    input wire logic presetn, // async reset, low
    input wire logic psel, // apb select
    input wire logic penable, // apb access phase
    input wire logic pwrite, // apb write
    input wire logic pready, // apb ready
    input wire logic pslverr, // apb error
    input wire logic stack_full, // call stack full
    input wire logic uart_clk_on, // serial clock running
    input wire logic irq_n, // vector pulse, low
    input wire logic irq, // level request
    input wire logic wake_req, // wake pulse
    input wire logic rx_ignore, // restart wait
    input wire logic uart_freeze // datapath hold
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    ////////////////////////////////////////
    // length of the current restart wait, so a short or long wait is caught when it ends
    logic [7:0] ign_len; // samples of rx_ignore high
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ign_len <= 8'h00;
        end else begin
            ign_len <= rx_ignore ? ign_len + 8'h01 : 8'h00;
        end
    end

    irq_n_pulse_a: assert property (!irq_n |=> irq_n)
        else $error("vector pulse longer than one cycle");
    stack_hold_a: assert property (!irq_n |-> !$past(stack_full))
        else $error("vector while stack full");
    restart_hold_a: assert property (!irq_n |-> !$past(rx_ignore))
        else $error("vector during restart wait");
    ignore_len_a: assert property ($fell(rx_ignore) |-> ign_len == RESTART_CYCLES)
        else $error("restart wait has wrong length");
    wake_pulse_a: assert property (wake_req |=> !wake_req && rx_ignore)
        else $error("wake pulse without restart wait");
    freeze_on_a: assert property ($fell(uart_clk_on) |-> ##[1:6] uart_freeze)
        else $error("no freeze after clock stop");
    freeze_off_a: assert property ($rose(uart_clk_on) |-> ##[1:6] !uart_freeze)
        else $error("no resume after clock return");
    irq_clear_a: assert property ($fell(irq) |-> $past(psel && penable && pwrite && pready))
        else $error("irq fell without a register write");
    ready_pulse_a: assert property (pready |=> !pready)
        else $error("pready longer than one cycle");
    err_ready_a: assert property (pslverr |-> pready && $past(psel && penable))
        else $error("error outside an access");
endmodule

bind uart_irq_wake uart_irq_wake_assertions #(.RESTART_CYCLES(RESTART_CYCLES)) i_chk (
    .pclk, .presetn, .psel, .penable, .pwrite, .pready, .pslverr, .stack_full,
    .uart_clk_on, .irq_n, .irq, .wake_req, .rx_ignore, .uart_freeze
);

// [sim/uart_far_side.sv]
// far side: core interrupt controller and remote serial sender
// assumes the bench commands a full stack and start bits on pclk
`timescale 1ns/1ns

module uart_far_side (
    input wire logic pclk, // system clock
    input wire logic presetn, // async reset, low
    input wire logic irq_n, // vector request from the block
    input wire logic hold_stack, // bench asks for a full stack
    input wire logic send_start, // bench asks for a start bit
    output logic stack_full, // call stack has no room
    output logic rx_pin, // serial line, driven high while idle
    output int vectors // low cycles of irq_n seen
);
    logic [3:0] low_cnt; // remaining low cycles of the start bit

    ////////////////////////////////////////
    // every low cycle counts, so a stuck request shows as extra vectors
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            stack_full <= 1'h0;
            rx_pin <= 1'h1;
            vectors <= 0;
            low_cnt <= 4'h0;
        end else begin
            stack_full <= hold_stack;
            if (!irq_n) begin
                vectors <= vectors + 1;
            end
            low_cnt <= send_start ? 4'h8 : (low_cnt != 4'h0 ? low_cnt - 4'h1 : 4'h0);
            rx_pin <= !(send_start || low_cnt > 4'h1);
        end
    end
endmodule

// [sim/test_uart_interrupt_wakeup.sv]
// self-checking bench of the serial-port interrupt and wake-up block
// assumes the map header is on the include path
`timescale 1ns/1ns
`include "uart_irq_wake_map.svh"

module test_uart_interrupt_wakeup;
    localparam int RS = 4; // shortened restart wait
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, e;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, q, v;
    logic [3:0] fl; // tx_empty, tx_idle, rx_avail, overrun
    logic [8:0] rx_word, w;
    logic uart_clk_on, hold, start, ad, nb, tp;
    wire stack_full, rx_pin, irq_n, irq, wake_req, rx_ignore, uart_freeze;
    int vectors, miscompares, checks_done, cyc, n0, cnt, wk;

    uart_irq_wake #(.RESTART_CYCLES(RS)) i_dut (.pclk, .presetn, .psel, .penable, .pwrite,
        .paddr, .pwdata, .prdata, .pready, .pslverr, .tx_empty(fl[0]), .tx_idle(fl[1]),
        .rx_avail_flag(fl[2]), .rx_overrun(fl[3]), .rx_word, .stack_full, .rx_pin,
        .uart_clk_on, .irq_n, .irq, .wake_req, .rx_ignore, .uart_freeze);
    uart_far_side i_far (.pclk, .presetn, .irq_n, .hold_stack(hold), .send_start(start),
        .stack_full, .rx_pin, .vectors);

    always #5 pclk = ~pclk;

    ////////////////////////////////////////
    task automatic end_sim();
        $display("checks %0d mismatches %0d", checks_done, miscompares);
        if (miscompares == 0 && checks_done > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask

    // hang guard, far above the length of the sequence
    always @(posedge pclk) begin
        cyc++;
        if (cyc == 10000) begin
            miscompares++;
            end_sim();
        end
    end

    task automatic chk(input string nm, input logic [31:0] x, input logic [31:0] g);
        checks_done++;
        if (g !== x) begin
            miscompares++;
            $display("MISMATCH %s expected %h seen %h", nm, x, g);
        end
    endtask

    // one apb transfer, held until pready is sampled high
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'h1;
        penable <= 1'h0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'h1;
        do @(posedge pclk); while (pready !== 1'h1);
        q = prdata;
        e = pslverr;
        psel <= 1'h0;
        penable <= 1'h0;
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] x, input string nm);
        apb(1'h0, a, 32'h0);
        chk(nm, x, q);
    endtask

    // mask bit of each flagged source; both receive sources share one
    function automatic logic [31:0] msk(input int i);
        return i == 0 ? 32'h40 : (i == 1 ? 32'h80 : 32'h100);
    endfunction

    // data interrupt unless address mode sees a low top bit
    function automatic logic [31:0] exp_rx(input logic a, input logic t);
        return (32'(a & t) << 4) | (32'(!a | t) << 2);
    endfunction

    ////////////////////////////////////////
    initial begin
        pclk = 1'h0; presetn = 1'h0; psel = 1'h0; penable = 1'h0; pwrite = 1'h0;
        paddr = 8'h00; pwdata = 32'h0; fl = 4'h0; rx_word = 9'h000;
        uart_clk_on = 1'h1; hold = 1'h0; start = 1'h0;
        void'($urandom(32'h11ED));
        repeat (16) @(posedge pclk);
        presetn <= 1'h1;
        rd(`UIW_OFF_CTRL, 32'h0, "ctrl_reset");
        rd(`UIW_OFF_IEN, 32'h0, "ien_reset");
        apb(1'h1, `UIW_OFF_ISTAT, 32'h3F);
        rd(`UIW_OFF_ISTAT, 32'h0, "istat_readonly");
        rd(`UIW_OFF_ICLR, 32'h0, "iclr_read");
        apb(1'h0, 8'h14, 32'h0);
        chk("unmapped_err", 32'h1, 32'(e));
        chk("unmapped_data", 32'h0, q);
        for (int i = 0; i < 4; i++) begin
            v = $urandom & 32'h7FF;
            apb(1'h1, `UIW_OFF_CTRL, v);
            rd(`UIW_OFF_CTRL, v, "ctrl_rw");
        end
        apb(1'h1, `UIW_OFF_IEN, 32'h3F);
        // each source with its mask open, then shut
        for (int m = 0; m < 2; m++) begin
            for (int i = 0; i < 4; i++) begin
                apb(1'h1, `UIW_OFF_CTRL, m ? 32'h7C3 & ~msk(i) : 32'h7C3);
                n0 = vectors;
                fl[i] <= 1'h1;
                repeat (6) @(posedge pclk);
                chk("vector", n0 + 1 - m, vectors);
                rd(`UIW_OFF_ISTAT, m ? 32'h0 : 32'h1 << i, "istat_src");
                chk("irq", 32'(1 - m), 32'(irq));
                apb(1'h1, `UIW_OFF_ICLR, 32'h3F);
                rd(`UIW_OFF_ISTAT, 32'h0, "istat_clear");
                fl[i] <= 1'h0;
            end
        end
        // address mode against both word lengths, parity kept off
        for (int k = 0; k < 8; k++) begin
            {ad, nb, tp} = 3'(k);
            apb(1'h1, `UIW_OFF_CTRL, 32'h7C3 | 32'(ad) << 4 | 32'(nb) << 3);
            w = 9'($urandom);
            w[nb ? 8 : 7] = tp;
            w[nb ? 7 : 8] = !tp;
            n0 = vectors;
            rx_word <= w;
            fl[2] <= 1'h1;
            repeat (6) @(posedge pclk);
            chk("addr_vector", n0 + int'(!ad | tp), vectors);
            rd(`UIW_OFF_ISTAT, exp_rx(ad, tp), "addr_istat");
            apb(1'h1, `UIW_OFF_ICLR, 32'h3F);
            fl[2] <= 1'h0;
        end
        // full stack holds the vector back until room returns
        apb(1'h1, `UIW_OFF_CTRL, 32'h7C3);
        hold <= 1'h1;
        repeat (2) @(posedge pclk);
        n0 = vectors;
        fl[0] <= 1'h1;
        repeat (8) @(posedge pclk);
        chk("stack_block", n0, vectors);
        hold <= 1'h0;
        repeat (6) @(posedge pclk);
        chk("stack_free", n0 + 1, vectors);
        apb(1'h1, `UIW_OFF_ICLR, 32'h3F);
        fl[0] <= 1'h0;
        // wake-up with the global enable off, then on
        for (int g = 0; g < 2; g++) begin
            v = 32'h323 | 32'(g) << 10;
            apb(1'h1, `UIW_OFF_CTRL, v);
            uart_clk_on <= 1'h0;
            repeat (8) @(posedge pclk);
            chk("freeze", 32'h1, 32'(uart_freeze));
            rd(`UIW_OFF_CTRL, v, "ctrl_kept");
            n0 = vectors;
            start <= 1'h1;
            @(posedge pclk);
            start <= 1'h0;
            cnt = 0;
            wk = 0;
            repeat (40) begin
                @(posedge pclk);
                cnt += int'(rx_ignore === 1'h1);
                wk += int'(wake_req === 1'h1);
            end
            chk("wake_pulse", 32'h1, wk);
            chk("ignore_len", RS, cnt);
            chk("wake_vector", n0 + g, vectors);
            rd(`UIW_OFF_ISTAT, 32'h20, "wake_istat");
            apb(1'h1, `UIW_OFF_ICLR, 32'h3F);
            uart_clk_on <= 1'h1;
            repeat (8) @(posedge pclk);
            chk("resume", 32'h0, 32'(uart_freeze));
        end
        end_sim();
    end
endmodule
